// *** tcm_pkg.sv ***
/*
 * constants and types shared by the tightly-coupled memory enable block
 * and its ram interface stage.
 * assumes a 32-bit core address space with 64 MB regions at the bottom.
 */
package tcm_pkg;

   // ----------------------------------------------------------------
   // register map, byte addresses on the axi4-lite slave
   // ----------------------------------------------------------------
   localparam logic [7:0]  TCM_CTRL_OFF     = 8'h00;
   localparam logic [7:0]  TCM_STATUS_OFF   = 8'h04;
   localparam int          TCM_IRAM_EN_BIT  = 12;
   localparam int          TCM_DRAM_EN_BIT  = 2;
   localparam logic [31:0] TCM_CTRL_RST     = 32'h0000_0000;
   localparam logic [1:0]  TCM_RESP_OKAY    = 2'h0;
   localparam logic [1:0]  TCM_RESP_SLVERR  = 2'h2;

   // ----------------------------------------------------------------
   // memory map and boot vectors
   // ----------------------------------------------------------------
   localparam int          TCM_REGION_LSB   = 26;
   localparam logic [5:0]  TCM_REGION_I     = 6'h00;
   localparam logic [5:0]  TCM_REGION_D     = 6'h01;
   localparam logic [31:0] TCM_BOOT_LO      = 32'h0000_0000;
   localparam logic [31:0] TCM_BOOT_HI      = 32'hffff_0000;

   // ----------------------------------------------------------------
   // ram geometry: 32 KB per memory, word index and segment split
   // ----------------------------------------------------------------
   localparam int          TCM_IDX_W        = 13;
   localparam int          TCM_SEG_IDX_W    = 11;
   localparam int          TCM_SEG_LSB      = 11;
   localparam int          TCM_NSEG         = 4;
   localparam int          TCM_NLANE        = 4;

   // wrapper organisations of the compiled sram
   typedef enum logic [1:0] {
      TCM_ORG_SINGLE = 2'h0,
      TCM_ORG_WORD4  = 2'h1,
      TCM_ORG_BYTE4  = 2'h3
   } tcm_org_e;

   // whole design state of the top module; in_reset_q for the checks is kept apart
   typedef struct packed {
      logic [31:0] ctrl;
      logic        strap;
      logic        aw_got;
      logic [7:0]  aw_addr;
      logic        w_got;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        i_ret;
      logic        d_ret_i;
      logic        d_ret_d;
      logic [15:0] bus_count;
   } tcm_state_s;

endpackage

// *** tcm_ram_if.sv ***
/*
 * request bundle from the fixed ram control to a memory interface stage.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface tcm_ram_if;
   logic        req;
   logic        write;
   logic [3:0]  byte_en;
   logic [12:0] word_index;

   modport ctl (output req, output write, output byte_en, output word_index);
   modport ifs (input req, input write, input byte_en, input word_index);
endinterface

// *** tcm_ram_stage.sv ***
/*
 * memory-specific interface stage: turns one ram request into selects,
 * write strobe and byte-lane writes for the chosen sram organisation.
 * assumes synchronous srams that sample all inputs on the rising clock.
 */
`timescale 1ns/100ps
module tcm_ram_stage
   import tcm_pkg::*;
#(
   parameter tcm_org_e ORG = TCM_ORG_SINGLE
) (
   // clock and reset, used by checks only
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // request from the ram control
   tcm_ram_if.ifs           rq,
   // pins of the wrapped sram
   output logic [15:0]      ram_select,
   output logic             ram_write_strobe,
   output logic [3:0]       byte_lane_write,
   output logic [12:0]      ram_word_index
);

   logic [1:0] seg;

   // address and strobes; word and byte segments see only the low 11 index bits, a single segment sees all 13
   always_comb begin
      seg              = rq.word_index[TCM_SEG_LSB +: 2];
      ram_write_strobe = rq.req & rq.write;
      byte_lane_write  = (rq.req & rq.write) ? rq.byte_en : 4'h0;
      if (ORG == TCM_ORG_SINGLE) begin
         ram_word_index = rq.word_index;
      end else begin
         ram_word_index = {2'h0, rq.word_index[TCM_SEG_IDX_W-1:0]};
      end
   end

   // one select per segment and lane; only synchronous srams are driven,
   // so a select per segment suffices and no per-segment strobes exist
   // (R17) select generation
   // (R18) synchronous only
   for (genvar s = 0; s < TCM_NSEG; s++) begin : g_seg
      for (genvar b = 0; b < TCM_NLANE; b++) begin : g_lane
         if (ORG == TCM_ORG_SINGLE) begin : g_one
            // (R14) one select used
            assign ram_select[s*4+b] = (s == 0 && b == 0) ? rq.req : 1'b0;
         end else if (ORG == TCM_ORG_WORD4) begin : g_word
            // (R15) segment decode bits
            assign ram_select[s*4+b] = (b == 0) ? (rq.req & (seg == 2'(s))) : 1'b0;
         end else begin : g_byte
            // (R16) split by lanes
            assign ram_select[s*4+b] = rq.req & (seg == 2'(s)) & (~rq.write | rq.byte_en[b]);
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_single_select: assert property ( // (R14)
      (ORG == TCM_ORG_SINGLE) |-> (ram_select == {15'h0, rq.req}))
      else $error("single segment select wrong");
   chk_segment_onehot: assert property ( // (R15)
      (ORG == TCM_ORG_WORD4 && rq.req) |-> (ram_select == (16'h1 << {seg, 2'h0})))
      else $error("segment select not decoded from index");
   chk_byte_split: assert property ( // (R16)
      (ORG == TCM_ORG_BYTE4 && rq.req && rq.write)
         |-> (ram_select[{seg, 2'h0} +: 4] == rq.byte_en) && ((ram_select & ~(16'hf << {seg, 2'h0})) == 16'h0))
      else $error("byte selects do not follow lane writes");
endmodule

// *** tcm_enable_ctrl.sv ***
/*
 * tightly-coupled memory enable and routing block with ram wrappers.
 * holds the memory enables, routes core fetches and data accesses to the
 * instruction ram, data ram or system bus, and drives both wrapped srams.
 * assumes the core issues at most one fetch and one data access a cycle,
 * that stalls are produced elsewhere, and that sram write data is taken
 * straight from the core.
 */
`timescale 1ns/100ps

// Operation
// (R1) strap low: both memories leave reset disabled
// (R2) strap high: both enabled, contents kept
// (R3) cold boot with strap: system selects high vector
// (R4) high vector low boots from address zero
// (R5) enable bit 12 enables instruction ram
// (R6) clearing bit 12 routes to bus
// (R7) software changes enables by read-modify-write
// (R8) disabling never alters stored contents
// (R9) enable bit 2 enables data ram
// (R10) clearing bit 2 routes to bus
// (R11) instruction range routing follows own enable
// (R12) software loads code before enabling fetch
// (R13) memory sizes set independently, 64 MB max; code fixes both at 32 KB
// (R14) single segment: one select, 13-bit index
// (R15) four word segments decoded by bits 12:11
// (R16) byte segments: lane writes split selects
// (R17) per-memory stage makes select, strobe, lanes
// (R18) only synchronous ram supported
// (R19) bottom 64 MB instruction, next data, aliased
// (R20) read data returns one cycle later
// (R21) fetches to data range go to bus
// (R22) strap sampled in reset, loaded at release
module tcm_enable_ctrl
   import tcm_pkg::*;
#(
   parameter tcm_org_e I_ORG = TCM_ORG_SINGLE,
   parameter tcm_org_e D_ORG = TCM_ORG_SINGLE
) (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // boot straps
   input  wire logic        ram_enable_strap,
   input  wire logic        high_vector_select,
   output logic [31:0]      reset_vector,
   // axi4-lite write address and data
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // core instruction fetch
   input  wire logic        ifetch_req,
   input  wire logic [31:0] ifetch_addr,
   output logic             ifetch_to_iram,
   output logic             ifetch_to_bus,
   output logic             ifetch_hold,
   output logic             ifetch_rvalid,
   output logic [31:0]      ifetch_rdata,
   // core data access
   input  wire logic        data_req,
   input  wire logic [31:0] data_addr,
   input  wire logic        data_write,
   input  wire logic [3:0]  data_byte_en,
   output logic             data_to_iram,
   output logic             data_to_dram,
   output logic             data_to_bus,
   output logic             data_rvalid,
   output logic [31:0]      data_rdata,
   // instruction sram pins
   output logic [15:0]      iram_select,
   output logic             iram_write_strobe,
   output logic [3:0]       iram_byte_lane_write,
   output logic [12:0]      iram_word_index,
   input  wire logic [31:0] iram_rdata,
   // data sram pins
   output logic [15:0]      dram_select,
   output logic             dram_write_strobe,
   output logic [3:0]       dram_byte_lane_write,
   output logic [12:0]      dram_word_index,
   input  wire logic [31:0] dram_rdata
);

   tcm_state_s st;
   tcm_state_s next_st;
   logic       i_en;
   logic       d_en;
   logic       fetch_in_i;
   logic       fetch_in_d;
   logic       data_in_i;
   logic       data_in_d;
   logic       want_iram;
   logic       do_write;
   logic       do_read;
   logic [31:0] wmask;

   tcm_ram_if iram_rq ();
   tcm_ram_if dram_rq ();

   // ----------------------------------------------------------------
   // address decode and routing
   // ----------------------------------------------------------------
   // only the region field is decoded, so a small memory aliases over
   // its whole 64 MB region; the word index just drops upper bits
   // (R19) region decode
   // (R13) one index width, TCM_IDX_W, shared by both memories
   always_comb begin
      i_en       = st.ctrl[TCM_IRAM_EN_BIT];
      d_en       = st.ctrl[TCM_DRAM_EN_BIT];
      fetch_in_i = ifetch_addr[31:TCM_REGION_LSB] == TCM_REGION_I;
      fetch_in_d = ifetch_addr[31:TCM_REGION_LSB] == TCM_REGION_D;
      data_in_i  = data_addr[31:TCM_REGION_LSB] == TCM_REGION_I;
      data_in_d  = data_addr[31:TCM_REGION_LSB] == TCM_REGION_D;
   end

   // (R5) enabled instruction ram
   // (R6) disabled goes to bus
   // (R11) own enable only
   assign data_to_iram = data_req & data_in_i & i_en;
   // (R9) enabled data ram
   // (R10) disabled goes to bus
   assign data_to_dram = data_req & data_in_d & d_en;
   assign data_to_bus  = data_req & ~data_to_iram & ~data_to_dram;

   // the instruction ram has one port; a data access wins and the fetch is
   // held for a cycle rather than dropped
   assign want_iram      = ifetch_req & fetch_in_i & i_en;
   assign ifetch_to_iram = want_iram & ~data_to_iram;
   assign ifetch_hold    = want_iram & data_to_iram;
   // (R21) fetches never use data ram
   assign ifetch_to_bus  = ifetch_req & ~(fetch_in_i & i_en);

   // (R4) boot vector select
   assign reset_vector = high_vector_select ? TCM_BOOT_HI : TCM_BOOT_LO;

   // ----------------------------------------------------------------
   // requests to the two wrapped srams
   // ----------------------------------------------------------------
   // (R8) no ram access while disabled
   always_comb begin
      iram_rq.req        = ifetch_to_iram | data_to_iram;
      iram_rq.write      = data_to_iram & data_write;
      iram_rq.byte_en    = data_byte_en;
      iram_rq.word_index = data_to_iram ? data_addr[2 +: TCM_IDX_W] : ifetch_addr[2 +: TCM_IDX_W];
      dram_rq.req        = data_to_dram;
      dram_rq.write      = data_to_dram & data_write;
      dram_rq.byte_en    = data_byte_en;
      dram_rq.word_index = data_addr[2 +: TCM_IDX_W];
   end

   // (R17) one stage per memory
   tcm_ram_stage #(.ORG(I_ORG)) u_istage (
      .aclk             (aclk),
      .aresetn          (aresetn),
      .rq               (iram_rq.ifs),
      .ram_select       (iram_select),
      .ram_write_strobe (iram_write_strobe),
      .byte_lane_write  (iram_byte_lane_write),
      .ram_word_index   (iram_word_index)
   );

   tcm_ram_stage #(.ORG(D_ORG)) u_dstage (
      .aclk             (aclk),
      .aresetn          (aresetn),
      .rq               (dram_rq.ifs),
      .ram_select       (dram_select),
      .ram_write_strobe (dram_write_strobe),
      .byte_lane_write  (dram_byte_lane_write),
      .ram_word_index   (dram_word_index)
   );

   // ----------------------------------------------------------------
   // read return, one cycle after the sram access
   // ----------------------------------------------------------------
   // (R20) single-cycle read
   assign ifetch_rvalid = st.i_ret;
   assign ifetch_rdata  = iram_rdata;
   assign data_rvalid   = st.d_ret_i | st.d_ret_d;
   assign data_rdata    = st.d_ret_i ? iram_rdata : dram_rdata;

   // ----------------------------------------------------------------
   // axi4-lite slave
   // ----------------------------------------------------------------
   assign s_axi_awready = ~st.aw_got & ~st.bvalid;
   assign s_axi_wready  = ~st.w_got & ~st.bvalid;
   assign s_axi_bvalid  = st.bvalid;
   assign s_axi_bresp   = st.bresp;
   assign s_axi_arready = ~st.rvalid;
   assign s_axi_rvalid  = st.rvalid;
   assign s_axi_rdata   = st.rdata;
   assign s_axi_rresp   = st.rresp;

   assign do_write = st.aw_got & st.w_got & ~st.bvalid;
   assign do_read  = s_axi_arvalid & ~st.rvalid;

   // next state; reset is synchronous and also samples the strap, so the
   // enables come out of reset with the last value seen during it
   always_comb begin
      next_st = st;
      wmask   = {{8{st.wstrb[3]}}, {8{st.wstrb[2]}}, {8{st.wstrb[1]}}, {8{st.wstrb[0]}}};
      // address and data in either order
      if (s_axi_awvalid && s_axi_awready) begin
         next_st.aw_got  = 1'b1;
         next_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_st.w_got = 1'b1;
         next_st.wdata = s_axi_wdata;
         next_st.wstrb = s_axi_wstrb;
      end
      if (do_write) begin
         next_st.aw_got = 1'b0;
         next_st.w_got  = 1'b0;
         next_st.bvalid = 1'b1;
         // (R7) byte strobes keep other bits
         if (st.aw_addr == TCM_CTRL_OFF) begin
            next_st.ctrl  = (st.ctrl & ~wmask) | (st.wdata & wmask);
            next_st.bresp = TCM_RESP_OKAY;
         end else if (st.aw_addr == TCM_STATUS_OFF) begin
            next_st.bresp = TCM_RESP_OKAY;
         end else begin
            next_st.bresp = TCM_RESP_SLVERR;
         end
      end else if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      // reads answer in the cycle after the address is taken
      if (do_read) begin
         next_st.rvalid = 1'b1;
         if (s_axi_araddr == TCM_CTRL_OFF) begin
            next_st.rdata = st.ctrl;
            next_st.rresp = TCM_RESP_OKAY;
         end else if (s_axi_araddr == TCM_STATUS_OFF) begin
            next_st.rdata = {st.bus_count, 13'h0, d_en, i_en, st.strap};
            next_st.rresp = TCM_RESP_OKAY;
         end else begin
            next_st.rdata = 32'h0000_0000;
            next_st.rresp = TCM_RESP_SLVERR;
         end
      end else if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
      // read-return markers and bus traffic count for status
      next_st.i_ret   = ifetch_to_iram;
      next_st.d_ret_i = data_to_iram & ~data_write;
      next_st.d_ret_d = data_to_dram & ~data_write;
      if (ifetch_to_bus || data_to_bus) begin
         next_st.bus_count = st.bus_count + 16'h0001;
      end
      // (R22) strap sampled during reset
      // (R1) strap low disables both
      // (R2) strap high enables both
      if (!aresetn) begin
         next_st                       = '0;
         next_st.ctrl                  = TCM_CTRL_RST;
         next_st.ctrl[TCM_IRAM_EN_BIT] = ram_enable_strap;
         next_st.ctrl[TCM_DRAM_EN_BIT] = ram_enable_strap;
         next_st.strap                 = ram_enable_strap;
      end
   end

   // state register; sram contents live outside and are never touched here
   always_ff @(posedge aclk) begin
      st <= next_st;
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic in_reset_q;
   always_ff @(posedge aclk) begin
      in_reset_q <= ~aresetn;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence seq_iram_fetch;
      ifetch_to_iram && !data_to_iram;
   endsequence
   sequence seq_data_read_d;
      data_to_dram && !data_write;
   endsequence

   chk_strap_release: assert property ( // (R22)
      in_reset_q |-> (i_en == $past(ram_enable_strap)) && (d_en == $past(ram_enable_strap)))
      else $error("enables not loaded from strap at release");
   chk_strap_low_off: assert property ( // (R1)
      (in_reset_q && !st.strap) |-> !i_en && !d_en)
      else $error("memory enabled after reset with strap low");
   chk_boot_vector: assert property ( // (R4)
      !high_vector_select |-> reset_vector == TCM_BOOT_LO)
      else $error("boot vector wrong with high vector low");
   chk_iram_enabled: assert property ( // (R5)
      (data_req && data_in_i && i_en) |-> data_to_iram && !data_to_bus && iram_rq.req)
      else $error("enabled instruction ram not used");
   chk_iram_disabled: assert property ( // (R6)
      (ifetch_req && fetch_in_i && !i_en) |-> ifetch_to_bus && !iram_rq.req)
      else $error("disabled instruction ram still fetched");
   chk_dram_enabled: assert property ( // (R9)
      (data_req && data_in_d && d_en) |-> data_to_dram && !data_to_bus)
      else $error("enabled data ram not used");
   chk_dram_disabled: assert property ( // (R10)
      (data_req && data_in_d && !d_en) |-> data_to_bus && !dram_write_strobe)
      else $error("disabled data ram still accessed");
   chk_no_write_off: assert property ( // (R8)
      !i_en |-> !iram_write_strobe && !iram_rq.req)
      else $error("disabled instruction ram written");
   chk_fetch_dregion: assert property ( // (R21)
      (ifetch_req && fetch_in_d) |-> ifetch_to_bus && !ifetch_to_iram)
      else $error("fetch to data region not on bus");
   chk_fetch_return: assert property ( // (R20)
      seq_iram_fetch |=> ifetch_rvalid ##1 !ifetch_rvalid || $past(ifetch_to_iram))
      else $error("fetch data not returned one cycle later");
   chk_data_return: assert property ( // (R20)
      seq_data_read_d |=> data_rvalid && st.d_ret_d)
      else $error("data read not returned one cycle later");
endmodule

// *** tcm_sram_model.sv ***
/*
 * behavioural synchronous sram standing behind one wrapper stage.
 * assumes the single-segment or four-segment word-wide organisation.
 */
`timescale 1ns/100ps
module tcm_sram_model (
   // clock
   input  wire logic        aclk,
   // wrapped sram pins
   input  wire logic [15:0] ram_select,
   input  wire logic        ram_write_strobe,
   input  wire logic [3:0]  byte_lane_write,
   input  wire logic [12:0] ram_word_index,
   input  wire logic [31:0] wr_data,
   output logic      [31:0] rd_data
);
   logic [31:0] mem [0:8191];
   logic [12:0] idx;

   // word segments carry the segment in the select position
   always_comb begin
      idx = ram_word_index;
      for (int s = 1; s < 4; s++) begin
         if (ram_select[4*s]) idx = {2'(s), ram_word_index[10:0]};
      end
   end

   // -------------------------------------------------------------
   // storage
   // -------------------------------------------------------------
   initial rd_data = 32'h0;
   // synchronous read, data one cycle after select
   // unselected output toggles so a stale value never passes for data
   always @(posedge aclk) begin
      if (|ram_select) begin
         for (int i = 0; i < 4; i++) begin
            if (ram_write_strobe && byte_lane_write[i]) begin
               mem[idx][8*i +: 8] <= wr_data[8*i +: 8];
            end
         end
         rd_data <= mem[idx];
      end else begin
         rd_data <= ~rd_data;
      end
   end
endmodule

// *** tb.sv ***
/*
 * self-checking bench for the tightly-coupled memory enable block.
 * assumes a single-segment instruction wrapper, a four-segment word-wide
 * data wrapper and one sram model per memory.
 */
`timescale 1ns/100ps
module tb;
   import tcm_pkg::*;
   logic aclk = 1'b0, aresetn, ram_enable_strap, high_vector_select, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic ifetch_req, ifetch_to_iram, ifetch_to_bus, ifetch_hold, ifetch_rvalid, data_req, data_write, data_to_iram;
   logic data_to_dram, data_to_bus, data_rvalid, iram_write_strobe, dram_write_strobe;
   logic [31:0] reset_vector, s_axi_wdata, s_axi_rdata, ifetch_addr, ifetch_rdata, data_addr, data_rdata, ram_wd;
   logic [31:0] iram_rdata, dram_rdata, v, a, d;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [3:0]  s_axi_wstrb, data_byte_en, iram_byte_lane_write, dram_byte_lane_write;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [15:0] iram_select, dram_select;
   logic [12:0] iram_word_index, dram_word_index;
   logic [33:0] exp_q [$];
   logic [31:0] exp_d [$];
   logic [31:0] exp_i [$];
   integer      fails = 0, compares = 0, seed = 32'h424ebe2f;

   // -------------------------------------------------------------
   // design, memories and clock
   // -------------------------------------------------------------
   tcm_enable_ctrl #(.D_ORG(TCM_ORG_WORD4)) i_dut (.*);
   tcm_sram_model i_iram (.aclk(aclk), .ram_select(iram_select), .ram_write_strobe(iram_write_strobe),
      .byte_lane_write(iram_byte_lane_write), .ram_word_index(iram_word_index), .wr_data(ram_wd), .rd_data(iram_rdata));
   tcm_sram_model i_dram (.aclk(aclk), .ram_select(dram_select), .ram_write_strobe(dram_write_strobe),
      .byte_lane_write(dram_byte_lane_write), .ram_word_index(dram_word_index), .wr_data(ram_wd), .rd_data(dram_rdata));
   always #2 aclk = ~aclk;

   // -------------------------------------------------------------
   // comparison, verdict and bounded waits
   // -------------------------------------------------------------
   task check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task wrap_up;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task tick_or_quit(inout integer n);
      @(posedge aclk);
      n++;
      if (n > 100) begin
         fails++;
         wrap_up;
      end
   endtask
   // results are paired with the oldest note, one transfer at a time
   always @(posedge aclk) begin
      if (s_axi_bvalid === 1'b1 && s_axi_bready) check("bresp", {s_axi_bresp, 32'h0}, exp_q.pop_front());
      if (s_axi_rvalid === 1'b1 && s_axi_rready) check("rresp rdata", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
      if (aresetn && data_rvalid !== 1'b0) begin
         check("data_rdata", data_rdata, (exp_d.size() > 0) ? exp_d.pop_front() : 32'hx);
      end
      if (aresetn && ifetch_rvalid !== 1'b0) begin
         check("ifetch_rdata", ifetch_rdata, (exp_i.size() > 0) ? exp_i.pop_front() : 32'hx);
      end
   end

   // -------------------------------------------------------------
   // bus and core drivers
   // -------------------------------------------------------------
   task axi_wr(input logic [7:0] ad, input logic [31:0] dt, input logic [1:0] rs);
      integer n;
      n = 0;
      exp_q.push_back({rs, 32'h0});
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {ad, dt, 4'hf};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      do begin
         tick_or_quit(n);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) s_axi_bready <= 1'b0;
      end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
   endtask
   task axi_rd(input logic [7:0] ad, input logic [33:0] e);
      integer n;
      n = 0;
      exp_q.push_back(e);
      @(posedge aclk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {ad, 2'b11};
      do begin
         tick_or_quit(n);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) {v, s_axi_rready} <= {s_axi_rdata, 1'b0};
      end while (s_axi_rready);
      @(posedge aclk);
   endtask
   // one core data access; route is {to_iram, to_dram, to_bus}
   task dacc(input logic [31:0] ad, input logic wr, input logic [31:0] e, input logic [2:0] rt);
      @(posedge aclk);
      {data_req, data_addr, data_write, ram_wd, data_byte_en} <= {1'b1, ad, wr, e, 4'hf};
      if (!wr && rt != 3'b001) exp_d.push_back(e);
      #1 check("data route", {data_to_iram, data_to_dram, data_to_bus}, rt);
      @(posedge aclk);
      data_req <= 1'b0;
   endtask
   task fetch(input logic [31:0] ad, input logic [1:0] rt, input logic [31:0] e);
      @(posedge aclk);
      {ifetch_req, ifetch_addr} <= {1'b1, ad};
      if (rt == 2'b10) exp_i.push_back(e);
      #1 check("fetch route", {ifetch_hold, ifetch_to_iram, ifetch_to_bus}, {1'b0, rt});
      @(posedge aclk);
      ifetch_req <= 1'b0;
   endtask
   task rst(input logic s);
      @(posedge aclk);
      {aresetn, ram_enable_strap} <= {1'b0, s};
      repeat (20) @(posedge aclk);
      {aresetn, ram_enable_strap} <= {1'b1, ~s};
   endtask

   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      {aresetn, ram_enable_strap, high_vector_select, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'b0;
      {s_axi_arvalid, s_axi_rready, ifetch_req, data_req, data_write} = 5'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, ifetch_addr, data_addr, data_byte_en, ram_wd} = '0;
      rst(1'b0);
      #1 check("reset_vector", reset_vector, TCM_BOOT_LO);
      @(posedge aclk) high_vector_select <= 1'b1;
      #1 check("reset_vector", reset_vector, TCM_BOOT_HI);
      axi_rd(TCM_CTRL_OFF, {TCM_RESP_OKAY, 32'h0});
      dacc(32'h0000_0010, 1'b0, 32'h0, 3'b001);
      dacc(32'h0400_0010, 1'b0, 32'h0, 3'b001);
      axi_rd(8'h10, {TCM_RESP_SLVERR, 32'h0});
      axi_wr(8'h14, 32'h1004, TCM_RESP_SLVERR);
      rst(1'b1);
      axi_rd(TCM_CTRL_OFF, {TCM_RESP_OKAY, 32'h0000_1004});
      axi_rd(TCM_STATUS_OFF, {TCM_RESP_OKAY, 32'h0000_0007});
      dacc(TCM_BOOT_LO, 1'b1, 32'h5a5a_0ff0, 3'b100);
      dacc(TCM_BOOT_LO, 1'b0, 32'h5a5a_0ff0, 3'b100);
      fetch(TCM_BOOT_LO, 2'b10, 32'h5a5a_0ff0);
      fetch(32'h0400_0000, 2'b01, 32'h0);
      for (int k = 0; k < 4; k++) begin
         a = {6'h01, 26'($random(seed)) & 26'h3ff_fffc};
         d = $random(seed);
         dacc(a, 1'b1, d, 3'b010);
         check("dram index", {dram_select, dram_word_index}, {16'h1 << {a[14:13], 2'h0}, 2'h0, a[12:2]});
         dacc(a ^ 32'h0010_0000, 1'b0, d, 3'b010);
      end
      axi_rd(TCM_CTRL_OFF, {TCM_RESP_OKAY, 32'h0000_1004});
      axi_wr(TCM_CTRL_OFF, v & ~(32'h1 << TCM_DRAM_EN_BIT), TCM_RESP_OKAY);
      dacc(a, 1'b0, d, 3'b001);
      axi_rd(TCM_CTRL_OFF, {TCM_RESP_OKAY, 32'h0000_1000});
      axi_wr(TCM_CTRL_OFF, v | (32'h1 << TCM_DRAM_EN_BIT), TCM_RESP_OKAY);
      dacc(a, 1'b0, d, 3'b010);
      axi_wr(TCM_CTRL_OFF, 32'h0000_0004, TCM_RESP_OKAY);
      fetch(32'h0000_0040, 2'b01, 32'h0);
      dacc(32'h0000_0040, 1'b0, 32'h0, 3'b001);
      repeat (4) @(posedge aclk);
      wrap_up;
   end
endmodule
